// *** shared/dca_pkg.sv ***
// Shared constants for the dual channel allegiance and status block.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
package dca_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] DCA_OFS_CTRL = 8'h00;
    localparam logic [7:0] DCA_OFS_NSC_STAT = 8'h04;
    localparam logic [7:0] DCA_OFS_ESC_TIO = 8'h08;
    localparam logic [7:0] DCA_OFS_IRQ = 8'h0C;
    localparam logic [7:0] DCA_OFS_CAPT = 8'h10;
    localparam logic [7:0] DCA_OFS_STATE = 8'h14;

    // ----------------------------------------------------------------
    // Status codes
    // ----------------------------------------------------------------
    localparam logic [7:0] DCA_ST_ZERO = 8'h00;
    localparam logic [7:0] DCA_ST_UC = 8'h02;
    localparam logic [7:0] DCA_ST_CE = 8'h08;
    localparam logic [7:0] DCA_ST_CEDE = 8'h0C;
    localparam logic [7:0] DCA_ST_BUSY = 8'h10;
    localparam logic [7:0] DCA_ST_CUBUSY = 8'h70;
    localparam logic [7:0] DCA_ST_DE = 8'h04;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] DCA_CMD_TIO = 8'h00;
    localparam logic [7:0] DCA_CMD_NOP = 8'h03;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int DCA_B_BUSOUT_CHK = 3;
    localparam int DCA_B_STACKED = 5;
    localparam int DCA_B_NEUTRAL = 7;
    localparam int DCA_B_STCHAIN = 6;
    localparam int DCA_B_ENA = 0;
    localparam int DCA_B_ENB = 1;

    // Reset values
    localparam logic [31:0] DCA_RST_WORD = 32'h0000_0000;
    localparam logic [7:0] DCA_RST_BYTE = 8'h00;

    typedef enum logic [1:0] {
        DCA_AL_NEUTRAL = 2'b00,
        DCA_AL_INST = 2'b01,
        DCA_AL_IMPL = 2'b10,
        DCA_AL_CONT = 2'b11
    } dca_alleg_t;

endpackage : dca_pkg

// *** rtl/dca_top.sv ***
// Channel adapter selection status logic with dual host switch.
// Assumes channel selection requests are pulses synchronous to aclk.
//
// Function
// [RQ1] Test I/O to emulation address returns 70 when blocked or unloaded
// [RQ2] Loaded emulation test status returned to Test I/O of that address
// [RQ3] Stacked initial status raises initial-selection interrupt request
// [RQ4] Stacked zero status only arises from native Test I/O
// [RQ5] Stacked no-op CE/DE captures address, command and stacked flag
// [RQ6] Bus-out parity error gives unit check; stacking sets check flags
// [RQ7] Native status register zero when free, else held until accepted
// [RQ8] Software re-presents held native status rather than rewriting it
// [RQ9] Software treats stacked emulation Test I/O like stacked final status
// [RQ10] Each interface has own native address; emulation only partitioned
// [RQ11] Interfaces enable separately; disabled interface bypasses Select Out
// [RQ12] Never operate both interfaces at once; hardware resolves contention
// [RQ13] Allegiance holds from first command until unchained device end
// [RQ14] Selection from the other interface during allegiance gets busy
// [RQ15] After owner finishes, device end goes to the busied interface
// [RQ16] Single interface enabled accepts native and emulation addresses
// [RQ17] Neutral serves both; switched accepts commands only from owner
// [RQ18] Switched adapter answers other side by holding or short busy
// [RQ19] Instantaneous allegiance from neutral ends when status presented
// [RQ20] Zero status to transfer command starts implicit allegiance
// [RQ21] Disconnect keeps implicit allegiance until reset-to-neutral write
// [RQ22] Unit check ending holds contingent allegiance until new command
// [RQ23] Simultaneous selections: interface A wins, B stays pending
`timescale 1ns/10ps
module dca_top #(
    parameter logic [7:0] NSC_ADDR_A = 8'h20, // Native address on A
    parameter logic [7:0] NSC_ADDR_B = 8'h21, // Native address on B
    parameter logic [7:0] ESC_BASE = 8'h40 // First emulation address
) (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [7:0] awaddr, // Write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write strobes
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [7:0] araddr, // Read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic [1:0] sel_req, // Initial selection pulse per side
    input wire logic [1:0] poll_req, // Select Out poll pulse per side
    input wire logic [7:0] sel_addr, // Device address of selection
    input wire logic [7:0] sel_cmd, // Command byte of selection
    input wire logic sel_par_err, // Bus-out parity error on command
    input wire logic cmd_chain, // Command chaining flag
    input wire logic stat_take, // Channel accepted presented status
    input wire logic stat_stack, // Channel stacked presented status
    input wire logic disconnect, // Interface disconnect ended operation
    output logic [1:0] sel_bypass, // Select Out passed through per side
    output logic [1:0] sel_hold, // Selection held incomplete per side
    output logic stat_valid, // Status presented, one cycle
    output logic stat_side, // Side the status goes to
    output logic [7:0] stat_byte, // Status byte presented
    output logic irq_initsel // Initial selection interrupt request
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [1:0] en_q; // Interface enables
    logic [7:0] nsc_stat_q; // Native pending status
    logic [15:0] esc_tio_q; // Emulation test address and status
    logic esc_tio_vld_q;
    logic esc_busy_q; // Emulation ending status not accepted
    logic irq_q;
    logic [7:0] flags_q; // Byte 0 input flags
    logic [15:0] capt_q; // Captured address and command
    dca_pkg::dca_alleg_t al_q;
    logic own_q; // Owning side
    logic [1:0] busied_q; // Sides owed a device end
    logic [1:0] pend_q; // Held selections
    logic [7:0] last_st_q; // Last status offered
    logic last_tio_nsc_q;
    logic last_uc_q;
    logic last_nop_q;
    logic [15:0] last_cap_q;
    logic wait_q; // Waiting for accept or stack
    logic [1:0] bypass_q;
    logic [1:0] hold_q;
    logic sv_q;
    logic ss_q;
    logic [7:0] sb_q;
    logic aw_q;
    logic w_q;
    logic [7:0] waddr_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic wr_fire;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_val;

    // ----------------------------------------------------------------
    // Selection decode
    // ----------------------------------------------------------------
    logic [1:0] req;
    logic side;
    logic both_en;
    logic is_nsc;
    logic is_esc;
    logic [7:0] resp;
    logic go;
    logic owner_ok;

    assign req = (sel_req | pend_q) & en_q; // see [RQ11]
    assign side = req[0] ? 1'b0 : 1'b1; // see [RQ23]
    assign both_en = &en_q;
    assign is_nsc = sel_addr == (side ? NSC_ADDR_B : NSC_ADDR_A); // see [RQ10]
    assign is_esc = !both_en && (sel_addr[7:4] == ESC_BASE[7:4]); // see [RQ16]
    assign owner_ok = (al_q == dca_pkg::DCA_AL_NEUTRAL) ||
                      (own_q == side); // see [RQ17]
    assign go = (|req) && !wait_q && !sv_q;

    always_comb begin
        resp = dca_pkg::DCA_ST_ZERO;
        if (!owner_ok) begin
            resp = dca_pkg::DCA_ST_BUSY; // see [RQ14]
        end else if (sel_par_err) begin
            resp = dca_pkg::DCA_ST_UC; // see [RQ6]
        end else if (is_esc && sel_cmd == dca_pkg::DCA_CMD_TIO) begin
            if (irq_q || esc_busy_q || !esc_tio_vld_q ||
                esc_tio_q[15:8] != sel_addr) begin
                resp = dca_pkg::DCA_ST_CUBUSY; // see [RQ1]
            end else begin
                resp = esc_tio_q[7:0]; // see [RQ2]
            end
        end else if (irq_q) begin
            resp = dca_pkg::DCA_ST_CUBUSY;
        end else if (sel_cmd == dca_pkg::DCA_CMD_TIO) begin
            resp = nsc_stat_q; // see [RQ7]
        end else if (sel_cmd == dca_pkg::DCA_CMD_NOP) begin
            resp = dca_pkg::DCA_ST_CEDE;
        end
    end

    // ----------------------------------------------------------------
    // Channel side outputs
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bypass_q <= 2'b00;
            hold_q <= 2'b00;
        end else begin
            bypass_q <= poll_req & (~en_q | {2{wait_q}}); // see [RQ11]
            hold_q <= pend_q; // see [RQ18]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= 2'b00;
        end else if (go) begin
            // Loser of a tie or a request during a busy cycle waits
            pend_q <= req & ~(side ? 2'b10 : 2'b01); // see [RQ12]
        end else begin
            pend_q <= req;
        end
    end

    // Status presentation and device end owed to a busied side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sv_q <= 1'b0;
            ss_q <= 1'b0;
            sb_q <= dca_pkg::DCA_RST_BYTE;
        end else if (go) begin
            sv_q <= 1'b1;
            ss_q <= side;
            sb_q <= resp;
        end else if (al_q == dca_pkg::DCA_AL_NEUTRAL && |busied_q && !irq_q
                     && !wait_q && !sv_q) begin
            sv_q <= 1'b1; // see [RQ15]
            ss_q <= busied_q[0] ? 1'b0 : 1'b1;
            sb_q <= dca_pkg::DCA_ST_DE;
        end else begin
            sv_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busied_q <= 2'b00;
        end else if (go && !owner_ok) begin
            busied_q[side] <= 1'b1; // see [RQ14]
        end else if (sv_q && sb_q == dca_pkg::DCA_ST_DE) begin
            busied_q[ss_q] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Presentation outcome
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_q <= 1'b0;
            last_st_q <= dca_pkg::DCA_RST_BYTE;
            last_tio_nsc_q <= 1'b0;
            last_uc_q <= 1'b0;
            last_nop_q <= 1'b0;
            last_cap_q <= 16'h0000;
        end else if (go) begin
            wait_q <= 1'b1;
            last_st_q <= resp;
            last_tio_nsc_q <= is_nsc && sel_cmd == dca_pkg::DCA_CMD_TIO;
            last_uc_q <= sel_par_err;
            last_nop_q <= sel_cmd == dca_pkg::DCA_CMD_NOP;
            last_cap_q <= {sel_addr, sel_cmd};
        end else if (stat_take || stat_stack) begin
            wait_q <= 1'b0;
        end
    end

    // Allegiance state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            al_q <= dca_pkg::DCA_AL_NEUTRAL;
            own_q <= 1'b0;
        end else if (wr_fire && ws_q[0] &&
                     wd_q[dca_pkg::DCA_B_NEUTRAL] &&
                     waddr_q == dca_pkg::DCA_OFS_NSC_STAT) begin
            al_q <= dca_pkg::DCA_AL_NEUTRAL; // see [RQ21]
        end else if (go && owner_ok) begin
            if (al_q == dca_pkg::DCA_AL_NEUTRAL) begin
                al_q <= dca_pkg::DCA_AL_INST; // see [RQ19]
                own_q <= side;
            end else if (al_q == dca_pkg::DCA_AL_CONT &&
                         sel_cmd != dca_pkg::DCA_CMD_TIO &&
                         sel_cmd != dca_pkg::DCA_CMD_NOP) begin
                al_q <= dca_pkg::DCA_AL_IMPL; // see [RQ22]
            end
        end else if (stat_take && wait_q && last_st_q != dca_pkg::DCA_ST_BUSY) begin
            unique case (al_q)
                dca_pkg::DCA_AL_INST: begin
                    if (last_st_q == dca_pkg::DCA_ST_ZERO &&
                        (!last_nop_q || cmd_chain)) begin
                        al_q <= dca_pkg::DCA_AL_IMPL; // see [RQ20]
                    end else if (last_uc_q) begin
                        al_q <= dca_pkg::DCA_AL_CONT; // see [RQ22]
                    end else begin
                        al_q <= dca_pkg::DCA_AL_NEUTRAL;
                    end
                end
                dca_pkg::DCA_AL_IMPL: begin
                    if (last_st_q[2] && !cmd_chain && !disconnect) begin
                        al_q <= last_st_q[1] ? dca_pkg::DCA_AL_CONT
                                             : dca_pkg::DCA_AL_NEUTRAL;
                    end // see [RQ13]
                end
                dca_pkg::DCA_AL_CONT: begin
                    al_q <= dca_pkg::DCA_AL_CONT;
                end
                dca_pkg::DCA_AL_NEUTRAL: begin
                    al_q <= dca_pkg::DCA_AL_NEUTRAL;
                end
            endcase
        end else if (stat_stack && wait_q && al_q == dca_pkg::DCA_AL_INST) begin
            al_q <= dca_pkg::DCA_AL_NEUTRAL;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------

    assign wr_fire = aw_q && w_q && !bvalid;
    assign wr_hit = waddr_q == dca_pkg::DCA_OFS_CTRL ||
                    waddr_q == dca_pkg::DCA_OFS_NSC_STAT ||
                    waddr_q == dca_pkg::DCA_OFS_ESC_TIO ||
                    waddr_q == dca_pkg::DCA_OFS_IRQ;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            waddr_q <= 8'h00;
            wd_q <= dca_pkg::DCA_RST_WORD;
            ws_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'b00;
        end else begin
            if (awvalid && awready) begin
                aw_q <= 1'b1;
                waddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_q <= 1'b1;
                wd_q <= wdata;
                ws_q <= wstrb;
            end
            if (wr_fire) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_hit ? 2'b00 : 2'b10;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    assign awready = !aw_q && !bvalid;
    assign wready = !w_q && !bvalid;

    always_comb begin
        rd_hit = 1'b1;
        unique case (araddr)
            dca_pkg::DCA_OFS_CTRL: rd_val = {30'h0, en_q};
            dca_pkg::DCA_OFS_NSC_STAT: rd_val = {24'h0, nsc_stat_q};
            dca_pkg::DCA_OFS_ESC_TIO: rd_val = {15'h0, esc_tio_vld_q, esc_tio_q};
            dca_pkg::DCA_OFS_IRQ: rd_val = {23'h0, irq_q, flags_q};
            dca_pkg::DCA_OFS_CAPT: rd_val = {16'h0, capt_q};
            dca_pkg::DCA_OFS_STATE: rd_val = {26'h0, esc_busy_q, busied_q,
                                              own_q, al_q};
            default: begin
                rd_val = dca_pkg::DCA_RST_WORD;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= dca_pkg::DCA_RST_WORD;
            rresp <= 2'b00;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_val;
            rresp <= rd_hit ? 2'b00 : 2'b10;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    assign arready = !rvalid;

    // ----------------------------------------------------------------
    // Software registers and stacked status capture
    // ----------------------------------------------------------------
    logic stacked_ev;
    assign stacked_ev = stat_stack && wait_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_q <= 2'b00;
            esc_tio_q <= 16'h0000;
            esc_tio_vld_q <= 1'b0;
        end else if (wr_fire && ws_q[0]) begin
            if (waddr_q == dca_pkg::DCA_OFS_CTRL) begin
                en_q <= wd_q[1:0]; // see [RQ11]
            end
            if (waddr_q == dca_pkg::DCA_OFS_ESC_TIO) begin
                esc_tio_q <= wd_q[15:0];
                esc_tio_vld_q <= wd_q[16];
            end
        end
    end

    // Native status: hardware keeps it until the channel takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nsc_stat_q <= dca_pkg::DCA_ST_ZERO;
        end else if (stat_take && wait_q && last_tio_nsc_q) begin
            nsc_stat_q <= dca_pkg::DCA_ST_ZERO; // see [RQ7]
        end else if (wr_fire && ws_q[0] &&
                     waddr_q == dca_pkg::DCA_OFS_NSC_STAT) begin
            nsc_stat_q <= {1'b0, wd_q[6:0]}; // see [RQ8]
        end
    end

    // Emulation command in progress until its ending status is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            esc_busy_q <= 1'b0;
        end else if (go && is_esc && resp == dca_pkg::DCA_ST_ZERO) begin
            esc_busy_q <= 1'b1;
        end else if (stat_take && wait_q && last_st_q[2]) begin
            esc_busy_q <= 1'b0; // see [RQ9]
        end
    end

    // Interrupt and flags: a new event wins over a software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
            flags_q <= dca_pkg::DCA_RST_BYTE;
            capt_q <= 16'h0000;
        end else if (stacked_ev) begin
            irq_q <= 1'b1; // see [RQ3]
            flags_q[dca_pkg::DCA_B_STACKED] <= 1'b1; // see [RQ5]
            flags_q[dca_pkg::DCA_B_BUSOUT_CHK] <= last_uc_q; // see [RQ6]
            flags_q[dca_pkg::DCA_B_STCHAIN] <=
                last_st_q == dca_pkg::DCA_ST_ZERO && last_tio_nsc_q; // see [RQ4]
            capt_q <= last_cap_q;
        end else if (wr_fire && ws_q[1] &&
                     waddr_q == dca_pkg::DCA_OFS_IRQ && wd_q[8]) begin
            irq_q <= 1'b0;
            flags_q <= dca_pkg::DCA_RST_BYTE;
        end
    end

    assign sel_bypass = bypass_q;
    assign sel_hold = hold_q;
    assign stat_valid = sv_q;
    assign stat_side = ss_q;
    assign stat_byte = sb_q;
    assign irq_initsel = irq_q;

endmodule : dca_top

// *** tb/dca_chan_model.sv ***
// Host channel model: accepts or stacks each presented status.
// Assumes status arrives as a one-cycle pulse from the adapter.
`timescale 1ns/10ps
module dca_chan_model (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic stat_valid, // Status offered
    input wire logic stack_en, // Stack instead of accept
    input wire logic slow, // Answer two cycles late
    output logic stat_take, // Status accepted
    output logic stat_stack // Status stacked
);
    logic [1:0] wait_q;
    logic busy_q;
    always_ff @(posedge aclk) begin
        stat_take <= 1'h0;
        stat_stack <= 1'h0;
        if (!aresetn) begin
            busy_q <= 1'h0;
            wait_q <= 2'h0;
        end else if (stat_valid) begin
            busy_q <= 1'h1;
            wait_q <= slow ? 2'h2 : 2'h0;
        end else if (busy_q && wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
        end else if (busy_q) begin
            busy_q <= 1'h0;
            stat_take <= !stack_en;
            stat_stack <= stack_en;
        end
    end
endmodule : dca_chan_model

// *** tb/dca_props.sv ***
// Checker for the allegiance and status block, attached by bind.
// Assumes the dca_top port set and a single clock domain.
`timescale 1ns/10ps
module dca_props (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic [1:0] sel_req, // Selection pulses
    input wire logic [1:0] poll_req, // Poll pulses
    input wire logic [7:0] sel_cmd, // Command byte
    input wire logic sel_par_err, // Parity error
    input wire logic stat_stack, // Status stacked
    input wire logic bvalid, // Write response valid
    input wire logic [1:0] sel_bypass, // Bypass per side
    input wire logic [1:0] sel_hold, // Held selection
    input wire logic stat_valid, // Status presented
    input wire logic stat_side, // Status side
    input wire logic [7:0] stat_byte, // Status byte
    input wire logic irq_initsel // Interrupt request
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence tie_s;
        stat_valid && $past(sel_req == 2'h3);
    endsequence
    sequence tio_blk_s;
        stat_valid && $past(|sel_req && !sel_par_err && irq_initsel
            && sel_cmd == dca_pkg::DCA_CMD_TIO);
    endsequence
    chk_tie_side: assert property (tie_s |-> !stat_side)
        else $error("tie not granted to side A");
    chk_tie_hold: assert property (tie_s |=> sel_hold[1])
        else $error("side B not held on tie");
    chk_status_pulse: assert property (stat_valid |=> !stat_valid)
        else $error("status stood longer than one cycle");
    chk_bypass_cause: assert property ($rose(sel_bypass[1])
        |-> $past(poll_req[1]) || $past(poll_req[1], 2))
        else $error("bypass without poll");
    chk_irq_stack: assert property (stat_stack |=> irq_initsel)
        else $error("no interrupt after stacked status");
    chk_irq_clear: assert property ($fell(irq_initsel)
        |-> ##[0:2] bvalid)
        else $error("interrupt dropped without write");
    chk_parity_uc: assert property (stat_valid && $past(|sel_req
        && sel_par_err && !irq_initsel) |-> stat_byte == dca_pkg::DCA_ST_UC)
        else $error("parity error not answered with unit check");
    chk_tio_busy: assert property (tio_blk_s
        |-> stat_byte == dca_pkg::DCA_ST_CUBUSY)
        else $error("blocked test io not answered with busy");
endmodule : dca_props
bind dca_top dca_props dca_props_i (.*);

// *** tb/dca_top_bench.sv ***
// Self-checking bench for dca_top with a host channel model.
// Assumes the package constants and the hand-over timing.
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
 $display("Error t=%0t got %h exp %h", $time, g, e); end end
module dca_top_bench;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, sel_par_err = 0, cmd_chain = 0;
    logic disconnect = 0, stack_en = 0, slow = 0, l_side;
    logic [7:0] awaddr = 0, araddr = 0, sel_addr = 0, sel_cmd = 0, l_byte;
    logic [31:0] wdata = 0, rd;
    logic [3:0] wstrb = 0;
    logic [1:0] sel_req = 0, poll_req = 0, rr;
    wire logic awready, wready, bvalid, arready, rvalid, stat_take;
    wire logic stat_stack, stat_valid, stat_side, irq_initsel;
    wire logic [1:0] bresp, rresp, sel_bypass, sel_hold;
    wire logic [31:0] rdata;
    wire logic [7:0] stat_byte;
    int miscompares = 0, cmp_count = 0, seen = 0;
    dca_top dca_top_i (.*);
    dca_chan_model dca_chan_model_i (.*);
    initial begin
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (stat_valid === 1'h1) begin
            seen <= seen + 1;
            l_side <= stat_side;
            l_byte <= stat_byte;
        end
    end
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic a_t, w_t, b_t;
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        do begin
            @(negedge aclk);
            a_t = (awvalid && awready) || (arvalid && arready);
            w_t = wvalid && wready;
            b_t = (bvalid && bready) || (rvalid && rready);
            rd = rdata;
            rr = w ? bresp : rresp;
            @(posedge aclk);
            if (a_t) begin
                awvalid <= 1'h0;
                arvalid <= 1'h0;
            end
            if (w_t) wvalid <= 1'h0;
            n++;
        end while (!b_t && n < 40);
        bready <= 1'h0;
        rready <= 1'h0;
        if (!b_t) `CHK(b_t, 1'h1)
    endtask : bus
    task expect_st(input int n0, input logic sd, input logic [7:0] e);
        int n;
        n = 0;
        while (seen == n0 && n < 40) begin
            @(posedge aclk);
            #1;
            n++;
        end
        `CHK(l_side, sd)
        `CHK(l_byte, e)
    endtask : expect_st
    task sel(input logic [1:0] s, input logic [7:0] a, c, input logic pe,
        input logic sd, input logic [7:0] e);
        int n0;
        n0 = seen;
        @(posedge aclk);
        sel_req <= s;
        sel_addr <= a;
        sel_cmd <= c;
        sel_par_err <= pe;
        @(posedge aclk);
        sel_req <= 2'h0;
        sel_par_err <= 1'h0;
        expect_st(n0, sd, e);
    endtask : sel
    task t_part;
        logic b;
        bus(0, 8'h04, 32'h0);
        `CHK(rd, 32'h0)
        bus(0, 8'h1c, 32'h0);
        `CHK(rr, 2'h2)
        bus(1, dca_pkg::DCA_OFS_CTRL, 32'h1);
        `CHK(rr, 2'h0)
        poll_req <= 2'h2;
        @(posedge aclk);
        poll_req <= 2'h0;
        #1 b = sel_bypass[1];
        @(posedge aclk);
        #1 b = b | sel_bypass[1];
        `CHK(b, 1'h1)
    endtask : t_part
    task t_stack;
        int n;
        stack_en <= 1'h1;
        sel(2'h1, 8'h20, 8'h02, 1'h1, 1'h0, dca_pkg::DCA_ST_UC);
        for (n = 0; n < 20 && irq_initsel !== 1'h1; n++) @(posedge aclk);
        stack_en <= 1'h0;
        `CHK(irq_initsel, 1'h1)
        bus(0, dca_pkg::DCA_OFS_IRQ, 32'h0);
        `CHK(rd[8:0], 9'h128)
        bus(0, dca_pkg::DCA_OFS_CAPT, 32'h0);
        `CHK(rd[15:8], 8'h20)
        sel(2'h1, 8'h41, 8'h00, 1'h0, 1'h0, dca_pkg::DCA_ST_CUBUSY);
        bus(1, dca_pkg::DCA_OFS_IRQ, 32'h0000_0100);
        `CHK(irq_initsel, 1'h0)
    endtask : t_stack
    task t_esc;
        sel(2'h1, 8'h41, 8'h00, 1'h0, 1'h0, dca_pkg::DCA_ST_CUBUSY);
        bus(1, dca_pkg::DCA_OFS_ESC_TIO, 32'h0001_4104);
        stack_en <= 1'h1;
        sel(2'h1, 8'h41, 8'h00, 1'h0, 1'h0, dca_pkg::DCA_ST_DE);
        repeat (2) @(posedge aclk);
        bus(0, dca_pkg::DCA_OFS_IRQ, 32'h0);
        `CHK(rd[8:0], 9'h120)
        bus(1, dca_pkg::DCA_OFS_IRQ, 32'h0000_0100);
        sel(2'h1, 8'h20, 8'h00, 1'h0, 1'h0, dca_pkg::DCA_ST_ZERO);
        repeat (2) @(posedge aclk);
        stack_en <= 1'h0;
        bus(0, dca_pkg::DCA_OFS_IRQ, 32'h0);
        `CHK(rd[8:0], 9'h160)
        bus(1, dca_pkg::DCA_OFS_IRQ, 32'h0000_0100);
    endtask : t_esc
    task t_busy_de;
        int n0;
        slow <= 1'h1;
        bus(1, dca_pkg::DCA_OFS_CTRL, 32'h3);
        sel(2'h1, 8'h20, 8'h02, 1'h0, 1'h0, dca_pkg::DCA_ST_ZERO);
        while (stat_take !== 1'h1) @(posedge aclk);
        bus(0, dca_pkg::DCA_OFS_STATE, 32'h0);
        `CHK(rd[2:0], 3'h2)
        bus(1, dca_pkg::DCA_OFS_IRQ, 32'h0000_0100);
        sel(2'h2, 8'h21, 8'h02, 1'h0, 1'h1, dca_pkg::DCA_ST_BUSY);
        n0 = seen;
        bus(1, dca_pkg::DCA_OFS_NSC_STAT, 32'h0000_0080);
        expect_st(n0, 1'h1, dca_pkg::DCA_ST_DE);
        slow <= 1'h0;
    endtask : t_busy_de
    task t_tie;
        int n;
        sel(2'h3, 8'h20, 8'h03, 1'h0, 1'h0, dca_pkg::DCA_ST_CEDE);
        `CHK(sel_hold[1], 1'h1)
        for (n = 0; n < 40 && sel_hold[1] !== 1'h0; n++) @(posedge aclk);
        `CHK(sel_hold[1], 1'h0)
    endtask : t_tie
    task wrap_up;
        $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    initial begin
        #100000;
        miscompares++;
        wrap_up;
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        t_part;
        t_stack;
        t_esc;
        t_busy_de;
        t_tie;
        repeat (10) @(posedge aclk);
        wrap_up;
    end
endmodule : dca_top_bench
